// ---- hw/otpp_defs.svh ----
`ifndef OTPP_DEFS_SVH
`define OTPP_DEFS_SVH

// Clock rate and pulse timing
`define OTPP_CLK_MHZ 100
`define OTPP_T_ACTIVE_US 20
`define OTPP_T_LOW_US 20
`define OTPP_T_BLOW_US 90
`define OTPP_ACTIVE_CYC (`OTPP_T_ACTIVE_US * `OTPP_CLK_MHZ)
`define OTPP_LOW_CYC (`OTPP_T_LOW_US * `OTPP_CLK_MHZ)
`define OTPP_BLOW_CYC (`OTPP_T_BLOW_US * `OTPP_CLK_MHZ)
`define OTPP_CNT_W 16

// Mode keys
`define OTPP_KEY_BLOW 3'h1
`define OTPP_KEY_TRY 3'h2
`define OTPP_KEY_READ 3'h3

// Parameter keys
`define OTPP_KEY_GAIN 3'h1
`define OTPP_KEY_ZERO 3'h2
`define OTPP_KEY_TC 3'h3
`define OTPP_KEY_MARGIN 3'h4

// Field layout
`define OTPP_FIELD_W 9
`define OTPP_NUM_REGS 4
`define OTPP_LOCK_BIT 3
`define OTPP_IDX_GAIN 2'h0
`define OTPP_IDX_ZERO 2'h1
`define OTPP_IDX_TC 2'h2
`define OTPP_IDX_MARGIN 2'h3

// Synchronised input bit positions
`define OTPP_IN_MID 0
`define OTPP_IN_HIGH 1
`define OTPP_IN_SUP 2

`endif

// ---- hw/otpp_pkg.sv ----
package otpp_pkg;

    typedef enum logic [4:0] {
        OTPP_IDLE = 5'h01,
        OTPP_MKEY = 5'h02,
        OTPP_PKEY = 5'h04,
        OTPP_FIELD = 5'h08,
        OTPP_DONE = 5'h10
    } otpp_state_type;

    typedef enum logic [1:0] {
        OTPP_MODE_NONE = 2'h0,
        OTPP_MODE_BLOW = 2'h1,
        OTPP_MODE_TRY = 2'h2,
        OTPP_MODE_READ = 2'h3
    } otpp_mode_type;

    typedef enum logic [1:0] {
        OTPP_SYM_LOW = 2'h0,
        OTPP_SYM_MID = 2'h1,
        OTPP_SYM_HIGH = 2'h2
    } otpp_sym_type;

endpackage : otpp_pkg

// ---- hw/otpp_top.sv ----
`include "otpp_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module otpp_top import otpp_pkg::*; #(
    parameter int FW = `OTPP_FIELD_W,
    parameter int ACT_CYC = `OTPP_ACTIVE_CYC,
    parameter int LOW_CYC = `OTPP_LOW_CYC,
    parameter int BLOW_CYC = `OTPP_BLOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin_above_middle,
    input wire logic pin_above_top,
    input wire logic supply_ok,
    input wire logic [`OTPP_NUM_REGS*FW-1:0] fuse_state,
    output logic [FW-1:0] gain_code_q,
    output logic [FW-1:0] zero_code_q,
    output logic [FW-1:0] margin_code_q,
    output logic fuse_blow_q,
    output logic [1:0] fuse_reg_q,
    output logic [FW-1:0] fuse_mask_q,
    output logic [FW-1:0] read_data_q,
    output logic read_valid_q,
    output logic [1:0] mode_q,
    output logic locked_q
);

    localparam logic [`OTPP_CNT_W-1:0] ACT_CNT = `OTPP_CNT_W'(ACT_CYC);
    localparam logic [`OTPP_CNT_W-1:0] LOW_CNT = `OTPP_CNT_W'(LOW_CYC);
    localparam logic [`OTPP_CNT_W-1:0] BLOW_CNT = `OTPP_CNT_W'(BLOW_CYC);
    localparam logic [FW-1:0] CODE_MAX = {FW{1'b1}};
    localparam logic [FW-1:0] CODE_ONE = FW'(1);

    // Input synchronisers with agreement filter
    logic [2:0] in_s0_q, in_s1_q, in_s2_q, in_q;
    logic [2:0] in_d;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            in_d[i] = (in_s1_q[i] == in_s2_q[i]) ? in_s2_q[i] : in_q[i];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_s0_q <= 3'h0;
            in_s1_q <= 3'h0;
            in_s2_q <= 3'h0;
            in_q <= 3'h0;
        end else begin
            in_s0_q <= {supply_ok, pin_above_top, pin_above_middle};
            in_s1_q <= in_s0_q;
            in_s2_q <= in_s1_q;
            in_q <= in_d;
        end
    end

    // Core state
    otpp_state_type st_q, st_d;
    otpp_mode_type md_q, md_d;
    otpp_sym_type lvl, prev_q, prev_d;
    logic [`OTPP_CNT_W-1:0] dur_q, dur_d, gap_q, gap_d;
    logic pk_q, pk_d;
    logic [2:0] key_q, key_d;
    logic [1:0] sel_q, sel_d;
    logic [FW-1:0] shift_q, shift_d;
    logic [FW-1:0] try_q [`OTPP_NUM_REGS];
    logic [FW-1:0] try_d [`OTPP_NUM_REGS];
    logic [`OTPP_NUM_REGS-1:0] tact_q, tact_d;
    logic [FW-1:0] fuse_f [`OTPP_NUM_REGS];
    logic [FW-1:0] gain_d, zero_d, margin_d, rdat_d;
    logic blow_d, rval_d, lock_d;
    logic p_start, p_end, p_ok, p_bad, ok_mid, ok_high, aborted;

    always_comb begin
        for (int r = 0; r < `OTPP_NUM_REGS; r++) begin
            fuse_f[r] = fuse_state[r*FW +: FW];
        end
    end

    always_comb begin
        // Level decode, top wins over middle
        if (in_q[`OTPP_IN_HIGH]) lvl = OTPP_SYM_HIGH;
        else if (in_q[`OTPP_IN_MID]) lvl = OTPP_SYM_MID;
        else lvl = OTPP_SYM_LOW;
        prev_d = lvl;
        p_start = (prev_q == OTPP_SYM_LOW) && (lvl != OTPP_SYM_LOW);
        p_end = (prev_q != OTPP_SYM_LOW) && (lvl == OTPP_SYM_LOW);
        p_ok = p_end && (dur_q >= ACT_CNT);
        p_bad = (p_end && !p_ok) || (p_start && (gap_q < LOW_CNT));
        ok_mid = p_ok && !pk_q;
        ok_high = p_ok && pk_q;
        aborted = !in_q[`OTPP_IN_SUP] || (p_bad && st_q != OTPP_IDLE);
        lock_d = fuse_f[`OTPP_IDX_MARGIN][`OTPP_LOCK_BIT];
        if (lvl != OTPP_SYM_LOW) begin
            dur_d = (dur_q == '1) ? dur_q : dur_q + 1'b1;
            pk_d = pk_q | (lvl == OTPP_SYM_HIGH);
            gap_d = '0;
        end else begin
            dur_d = '0;
            pk_d = 1'b0;
            gap_d = (gap_q == '1) ? gap_q : gap_q + 1'b1;
        end
        st_d = st_q;
        md_d = md_q;
        key_d = key_q;
        sel_d = sel_q;
        shift_d = shift_q;
        try_d = try_q;
        tact_d = tact_q;
        unique case (st_q)
            OTPP_IDLE: begin
                if (ok_high) begin
                    st_d = OTPP_MKEY;
                    key_d = 3'h0;
                end
            end
            OTPP_MKEY: begin
                if (ok_mid && key_q != 3'h7) key_d = key_q + 3'h1;
                if (ok_high) begin
                    st_d = OTPP_PKEY;
                    key_d = 3'h0;
                    if (key_q == `OTPP_KEY_BLOW && !lock_d) md_d = OTPP_MODE_BLOW;
                    else if (key_q == `OTPP_KEY_TRY && !lock_d) md_d = OTPP_MODE_TRY;
                    else if (key_q == `OTPP_KEY_READ) md_d = OTPP_MODE_READ;
                    else begin
                        st_d = OTPP_IDLE;
                        md_d = OTPP_MODE_NONE;
                    end
                end
            end
            OTPP_PKEY: begin
                if (ok_mid && key_q != 3'h7) key_d = key_q + 3'h1;
                if (ok_high) begin
                    if (key_q >= `OTPP_KEY_GAIN && key_q <= `OTPP_KEY_MARGIN &&
                        (key_q != `OTPP_KEY_TC || md_q == OTPP_MODE_READ)) begin
                        st_d = OTPP_FIELD;
                        sel_d = 2'(key_q - 3'h1);
                        shift_d = CODE_ONE;
                    end else begin
                        st_d = OTPP_IDLE;
                        md_d = OTPP_MODE_NONE;
                    end
                end
            end
            OTPP_FIELD: begin
                if (ok_mid && md_q == OTPP_MODE_TRY) begin
                    tact_d[sel_q] = 1'b1;
                    if (try_q[sel_q] != CODE_MAX) try_d[sel_q] = try_q[sel_q] + CODE_ONE;
                end
                if (ok_mid && md_q == OTPP_MODE_BLOW && !shift_q[FW-1]) shift_d = shift_q << 1;
                if (ok_high) begin
                    if (md_q == OTPP_MODE_BLOW) begin
                        st_d = (dur_q >= BLOW_CNT) ? OTPP_DONE : OTPP_IDLE;
                        if (dur_q < BLOW_CNT) md_d = OTPP_MODE_NONE;
                    end else begin
                        st_d = OTPP_PKEY;
                        key_d = 3'h0;
                    end
                end
            end
            OTPP_DONE: begin
                st_d = OTPP_DONE;
            end
        endcase
        if (aborted) begin
            st_d = OTPP_IDLE;
            md_d = OTPP_MODE_NONE;
            key_d = 3'h0;
        end
        blow_d = !aborted && st_q == OTPP_FIELD && md_q == OTPP_MODE_BLOW && !lock_d &&
                 lvl == OTPP_SYM_HIGH && pk_q && dur_q >= BLOW_CNT;
        rval_d = st_q == OTPP_FIELD && md_q == OTPP_MODE_READ && !aborted;
        rdat_d = rval_d ? fuse_f[sel_q] : '0;
        // Parameter follows the addressed code
        gain_d = tact_q[`OTPP_IDX_GAIN] ? try_q[`OTPP_IDX_GAIN] : fuse_f[`OTPP_IDX_GAIN];
        zero_d = tact_q[`OTPP_IDX_ZERO] ? try_q[`OTPP_IDX_ZERO] : fuse_f[`OTPP_IDX_ZERO];
        margin_d = tact_q[`OTPP_IDX_MARGIN] ? try_q[`OTPP_IDX_MARGIN] : fuse_f[`OTPP_IDX_MARGIN];
        if (st_q == OTPP_FIELD && md_q == OTPP_MODE_BLOW) begin
            if (sel_q == `OTPP_IDX_GAIN) gain_d = fuse_f[`OTPP_IDX_GAIN] | shift_q;
            if (sel_q == `OTPP_IDX_ZERO) zero_d = fuse_f[`OTPP_IDX_ZERO] | shift_q;
            if (sel_q == `OTPP_IDX_MARGIN) margin_d = fuse_f[`OTPP_IDX_MARGIN] | shift_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= OTPP_IDLE;
            md_q <= OTPP_MODE_NONE;
            prev_q <= OTPP_SYM_LOW;
            dur_q <= '0;
            gap_q <= '1;
            pk_q <= 1'b0;
            key_q <= 3'h0;
            sel_q <= 2'h0;
            shift_q <= CODE_ONE;
            tact_q <= '0;
            for (int r = 0; r < `OTPP_NUM_REGS; r++) try_q[r] <= '0;
            gain_code_q <= '0;
            zero_code_q <= '0;
            margin_code_q <= '0;
            fuse_blow_q <= 1'b0;
            fuse_reg_q <= 2'h0;
            fuse_mask_q <= '0;
            read_data_q <= '0;
            read_valid_q <= 1'b0;
            mode_q <= 2'h0;
            locked_q <= 1'b0;
        end else begin
            st_q <= st_d;
            md_q <= md_d;
            prev_q <= prev_d;
            dur_q <= dur_d;
            gap_q <= gap_d;
            pk_q <= pk_d;
            key_q <= key_d;
            sel_q <= sel_d;
            shift_q <= shift_d;
            tact_q <= tact_d;
            try_q <= try_d;
            gain_code_q <= gain_d;
            zero_code_q <= zero_d;
            margin_code_q <= margin_d;
            fuse_blow_q <= blow_d;
            fuse_reg_q <= sel_q;
            fuse_mask_q <= blow_d ? shift_q : '0;
            read_data_q <= rdat_d;
            read_valid_q <= rval_d;
            mode_q <= md_d;
            locked_q <= lock_d;
        end
    end

    sequence s_mid_done;
        st_q == OTPP_FIELD && md_q == OTPP_MODE_TRY && ok_mid && !aborted;
    endsequence

    sequence s_mode_close(logic [2:0] k);
        st_q == OTPP_MKEY && ok_high && !aborted && key_q == k && !lock_d;
    endsequence

    AST_BLOW_UNLOCKED: assert property (@(posedge clk) disable iff (!nrst)
        fuse_blow_q |-> !locked_q && $past(dur_q) >= BLOW_CNT)
        else $error("fuse blown while locked or short pulse");
    AST_BLOW_ONE_BIT: assert property (@(posedge clk) disable iff (!nrst)
        fuse_blow_q |-> $onehot(fuse_mask_q))
        else $error("blow mask not single bit");
    AST_TRY_KEY: assert property (@(posedge clk) disable iff (!nrst)
        s_mode_close(`OTPP_KEY_TRY) |=> md_q == OTPP_MODE_TRY && st_q == OTPP_PKEY)
        else $error("key 2 did not select try");
    AST_BLOW_KEY: assert property (@(posedge clk) disable iff (!nrst)
        s_mode_close(`OTPP_KEY_BLOW) |=> md_q == OTPP_MODE_BLOW)
        else $error("key 1 did not select blow");
    AST_TC_READ_ONLY: assert property (@(posedge clk) disable iff (!nrst)
        st_q == OTPP_FIELD && sel_q == `OTPP_IDX_TC |-> md_q == OTPP_MODE_READ)
        else $error("compensation reached outside read");
    AST_TRY_INC: assert property (@(posedge clk) disable iff (!nrst)
        s_mid_done ##0 (try_q[sel_q] != CODE_MAX) |=> try_q[sel_q] == $past(try_q[sel_q]) + CODE_ONE)
        else $error("try code did not step");
    AST_TRY_SAT: assert property (@(posedge clk) disable iff (!nrst)
        s_mid_done ##0 (try_q[sel_q] == CODE_MAX) |=> try_q[sel_q] == CODE_MAX)
        else $error("try code wrapped");
    AST_SUPPLY_ABORT: assert property (@(posedge clk) disable iff (!nrst)
        !in_q[`OTPP_IN_SUP] |=> st_q == OTPP_IDLE && md_q == OTPP_MODE_NONE ##1 !fuse_blow_q)
        else $error("supply drop did not abort");
    AST_SHORT_PULSE: assert property (@(posedge clk) disable iff (!nrst)
        p_end && dur_q < ACT_CNT |=> st_q == OTPP_IDLE)
        else $error("short pulse accepted");
    AST_READ_BACK: assert property (@(posedge clk) disable iff (!nrst)
        read_valid_q |-> read_data_q == $past(fuse_f[sel_q]))
        else $error("read data not fuse state");
    AST_LOCK_REFUSE: assert property (@(posedge clk) disable iff (!nrst)
        st_q == OTPP_MKEY && ok_high && !aborted && lock_d && key_q != `OTPP_KEY_READ |=>
        md_q == OTPP_MODE_NONE && st_q == OTPP_IDLE)
        else $error("locked part entered a writing mode");
    AST_READ_KEY: assert property (@(posedge clk) disable iff (!nrst)
        st_q == OTPP_MKEY && ok_high && !aborted && key_q == `OTPP_KEY_READ |=> md_q == OTPP_MODE_READ)
        else $error("key 3 did not select read");
    AST_BLOW_SHIFT: assert property (@(posedge clk) disable iff (!nrst)
        st_q == OTPP_FIELD && md_q == OTPP_MODE_BLOW && ok_mid && !aborted && !shift_q[FW-1] |=>
        shift_q == $past(shift_q) << 1)
        else $error("blow address did not shift");

endmodule : otpp_top

`default_nettype wire

// ---- testbench/otpp_programmer.sv ----
`timescale 1ns/1ns
`default_nettype none

module otpp_programmer #(
    parameter int FW = 9
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic fuse_blow_q,
    input wire logic [1:0] fuse_reg_q,
    input wire logic [FW-1:0] fuse_mask_q,
    output logic pin_above_middle,
    output logic pin_above_top,
    output logic supply_ok,
    output logic [4*FW-1:0] fuse_state
);
    // Just above the select and gap times set on the bench
    localparam int GAP = 205;
    localparam int ACT = 205;

    initial begin
        pin_above_middle = 1'b0;
        pin_above_top = 1'b0;
        supply_ok = 1'b1;
        fuse_state = '0;
    end

    // Fuse array survives supply cycling
    always @(posedge clk) begin
        if (fuse_blow_q === 1'b1) begin
            fuse_state[fuse_reg_q*FW +: FW] <= fuse_state[fuse_reg_q*FW +: FW] | fuse_mask_q;
        end
    end

    task automatic pulse(input int top, input int len);
        @(posedge clk);
        #1;
        pin_above_middle = 1'b1;
        pin_above_top = (top != 0);
        repeat (len) @(posedge clk);
        #1;
        pin_above_middle = 1'b0;
        pin_above_top = 1'b0;
        repeat (GAP) @(posedge clk);
    endtask : pulse

    task automatic high();
        pulse(1, ACT);
    endtask : high

    task automatic mids(input int n);
        repeat (n) pulse(0, ACT);
    endtask : mids

    task automatic supply(input logic v);
        @(posedge clk);
        #1;
        supply_ok = v;
    endtask : supply
endmodule : otpp_programmer

`default_nettype wire

// ---- testbench/tb_otpp_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_otpp_top import otpp_pkg::*;;
    localparam int FW = 9;
    logic clk;
    logic nrst;
    logic pin_above_middle;
    logic pin_above_top;
    logic supply_ok;
    logic [4*FW-1:0] fuse_state;
    logic [FW-1:0] gain_code_q;
    logic [FW-1:0] zero_code_q;
    logic [FW-1:0] margin_code_q;
    logic fuse_blow_q;
    logic [1:0] fuse_reg_q;
    logic [FW-1:0] fuse_mask_q;
    logic [FW-1:0] read_data_q;
    logic read_valid_q;
    logic [1:0] mode_q;
    logic locked_q;
    int fail_count;
    int checked;

    otpp_top #(.FW(FW), .ACT_CYC(200), .LOW_CYC(200), .BLOW_CYC(300)) otpp_top_inst (
        .clk(clk), .nrst(nrst), .pin_above_middle(pin_above_middle),
        .pin_above_top(pin_above_top), .supply_ok(supply_ok), .fuse_state(fuse_state),
        .gain_code_q(gain_code_q), .zero_code_q(zero_code_q), .margin_code_q(margin_code_q),
        .fuse_blow_q(fuse_blow_q), .fuse_reg_q(fuse_reg_q), .fuse_mask_q(fuse_mask_q),
        .read_data_q(read_data_q), .read_valid_q(read_valid_q), .mode_q(mode_q),
        .locked_q(locked_q)
    );

    otpp_programmer #(.FW(FW)) otpp_programmer_inst (
        .clk(clk), .nrst(nrst), .fuse_blow_q(fuse_blow_q), .fuse_reg_q(fuse_reg_q),
        .fuse_mask_q(fuse_mask_q), .pin_above_middle(pin_above_middle),
        .pin_above_top(pin_above_top), .supply_ok(supply_ok), .fuse_state(fuse_state)
    );

    always #5 clk = ~clk;

    task automatic wrap_up();
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic cycle_supply();
        @(posedge clk);
        #1;
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (10) @(posedge clk);
    endtask : cycle_supply

    task automatic wait_blow();
        int n;
        n = 0;
        while (fuse_blow_q !== 1'b1 && n < 400) begin
            @(posedge clk);
            #2;
            n++;
        end
        chk("fuse_blow_q", 16'h1, 16'(fuse_blow_q));
        if (fuse_blow_q !== 1'b1) wrap_up();
    endtask : wait_blow

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        fail_count = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (10) @(posedge clk);
        // Try mode, gain stepped one code per middle pulse
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(2);
        otpp_programmer_inst.high();
        chk("mode_q", 16'(OTPP_MODE_TRY), 16'(mode_q));
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        for (int i = 1; i <= 3; i++) begin
            otpp_programmer_inst.mids(1);
            chk("gain_code_q", 16'(i), 16'(gain_code_q));
        end
        chk("zero_code_q", 16'h0, 16'(zero_code_q));
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(4);
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(1);
        chk("margin_code_q", 16'h1, 16'(margin_code_q));
        chk("gain_code_q", 16'h3, 16'(gain_code_q));
        // Compensation key refused outside read
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(3);
        otpp_programmer_inst.high();
        chk("mode_q", 16'(OTPP_MODE_NONE), 16'(mode_q));
        // Short pulse abandons a started selection
        otpp_programmer_inst.high();
        otpp_programmer_inst.pulse(0, 100);
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        chk("mode_q", 16'(OTPP_MODE_NONE), 16'(mode_q));
        // Blow mode, one middle pulse addresses bit 1
        cycle_supply();
        chk("gain_code_q", 16'h0, 16'(gain_code_q));
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        chk("mode_q", 16'(OTPP_MODE_BLOW), 16'(mode_q));
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(1);
        fork
            otpp_programmer_inst.pulse(1, 310);
            begin
                wait_blow();
                chk("fuse_mask_q", 16'h2, 16'(fuse_mask_q));
                chk("fuse_reg_q", 16'h0, 16'(fuse_reg_q));
            end
        join
        cycle_supply();
        chk("gain_code_q", 16'h2, 16'(gain_code_q));
        // Lock fuse blown through the margin key
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(4);
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(3);
        fork
            otpp_programmer_inst.pulse(1, 310);
            begin
                wait_blow();
                chk("fuse_mask_q", 16'h8, 16'(fuse_mask_q));
                chk("fuse_reg_q", 16'h3, 16'(fuse_reg_q));
            end
        join
        cycle_supply();
        // Locked part refuses blow mode but still reads back
        chk("locked_q", 16'h1, 16'(locked_q));
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        chk("mode_q", 16'(OTPP_MODE_NONE), 16'(mode_q));
        otpp_programmer_inst.high();
        otpp_programmer_inst.mids(3);
        otpp_programmer_inst.high();
        chk("mode_q", 16'(OTPP_MODE_READ), 16'(mode_q));
        otpp_programmer_inst.mids(1);
        otpp_programmer_inst.high();
        chk("read_valid_q", 16'h1, 16'(read_valid_q));
        chk("read_data_q", 16'h2, 16'(read_data_q));
        otpp_programmer_inst.supply(1'b0);
        repeat (10) @(posedge clk);
        chk("mode_q", 16'(OTPP_MODE_NONE), 16'(mode_q));
        chk("read_valid_q", 16'h0, 16'(read_valid_q));
        wrap_up();
    end
endmodule : tb_otpp_top

`default_nettype wire
